// >>> aimr_pkg.sv
/*
  Constants shared by the ASCII input message router: register map,
  field positions, format codes, status words, character codes and timing.
  Assumes one 125 MHz clock and a 32-bit register port with 8-bit addresses.
*/
package aimr_pkg;
  localparam int MSG_MAX = 16;
  localparam int IMG_REGS = 16;
  localparam int NPATH = 4;
  localparam logic [4:0] RTS_LEVEL = 5'd8;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TCNT = 8'h01;
  localparam logic [7:0] A_TOUT = 8'h02;
  localparam logic [7:0] A_SIG = 8'h03;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [4:0] A_ACC_HI = 5'h02;
  localparam logic [4:0] A_TRM_HI = 5'h03;
  localparam logic [1:0] A_PATH_HI = 2'h1;
  localparam logic [3:0] A_IMG_HI = 4'h8;
  localparam logic [3:0] A_IST_HI = 4'ha;

  localparam logic [3:0] PO_CFG = 4'h0;
  localparam logic [3:0] PO_LEN = 4'h1;
  localparam logic [3:0] PO_PAT = 4'h2;
  localparam logic [3:0] PO_MSK = 4'h6;

  localparam int CTRL_CAP = 0;
  localparam int CTRL_SEVEN = 1;
  localparam int CFG_START = 0;
  localparam int CFG_COUNT = 8;
  localparam int CFG_FMT = 16;
  localparam int CFG_CONT = 24;
  localparam int LEN_PAT = 0;
  localparam int LEN_MSK = 8;

  localparam logic [1:0] FMT_ASCII = 2'h0;
  localparam logic [1:0] FMT_PACKED = 2'h1;
  localparam logic [1:0] FMT_INT = 2'h2;
  localparam logic [1:0] FMT_FLOAT = 2'h3;

  localparam logic [15:0] STAT_IN = 16'he000;
  localparam logic [15:0] STAT_OUT = 16'ha000;

  localparam logic [7:0] CH_US = 8'h5f;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [6:0] CH_D0 = 7'h30;
  localparam logic [6:0] CH_D9 = 7'h39;

  localparam int HUNDREDTH_NS = 10000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_CYC = HUNDREDTH_NS / CLK_PERIOD_NS;
endpackage

// >>> aimr_router.sv
/*
  Input path of one serial data port: character filter, message
  framing, case folding, four pattern paths, masking, editing and the
  rack image table with its toggle register.
  Assumes received bytes arrive already deframed on the same clock.
*/
// Our own choices: the strobed register port and the register addresses.
// How it works
// - Accepted characters append to message buffer
// - Terminate character completes message, starts processing
// - Character in both tables: stored, then ends
// - Characters in neither table are discarded
// - Terminator flash only with non-empty buffer
// - Length limit or silence also ends message
// - Tables see full byte; rest sees seven bits
// - Capitalize folds lower case before matching
// - Paths tried in order; first match wins
// - Unmatched message dropped, collection resumes
// - Pattern indicator lights on any trigger
// - Underscore in mask keeps message character
// - Other mask characters replace message character
// - Masked length is shorter of both
// - ASCII and packed restore original top bit
// - Data written from start register, count registers
// - Integer one, float two registers, rest zeroed
// - Continue retests later paths with same message
// - Signal register: four bits per port
// - Every trigger toggles its path bit
// - Status words: E000 input, A000 output
// - RTS drops while backlog, sender then pauses
// - Silence counted in hundredths; zero disables
// - Length limit zero disables length termination
// - Seven-bit mode clears received top bit
`timescale 1ns/1ps
module aimr_router #(
  parameter int TICK_CYC = aimr_pkg::TICK_CYC,
  parameter logic [1:0] PORT_IDX = 2'd0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic rts,
  output logic term_led,
  output logic pat_led
);
  import aimr_pkg::*;

  typedef enum logic [1:0] {P_IDLE, P_MATCH, P_WRITE} aimr_ph_t;

  typedef struct packed {
    logic cap;
    logic seven;
    logic [4:0] tcnt;
    logic [15:0] tout;
    logic [255:0] acc;
    logic [255:0] trm;
    logic [3:0][15:0][7:0] pat;
    logic [3:0][15:0][7:0] msk;
    logic [3:0][4:0] plen;
    logic [3:0][4:0] mlen;
    logic [3:0][3:0] start;
    logic [3:0][4:0] cnt;
    logic [3:0][1:0] fmt;
    logic [3:0] cont;
    logic [15:0][7:0] cbuf;
    logic [4:0] clen;
    logic pend;
    logic [15:0][7:0] wbuf;
    logic [4:0] wlen;
    aimr_ph_t ph;
    logic [1:0] pi;
    logic [4:0] k;
    logic [15:0] sig;
    logic [15:0][15:0] img;
    logic [31:0] tick;
    logic [15:0] sil;
    logic [31:0] rdata;
    logic term_led;
    logic pat_led;
  } aimr_st_t;

  localparam aimr_st_t ST_RST = '0;

  aimr_st_t st_ff;
  aimr_st_t nxt_st;

  logic [7:0] ch;
  logic acc_hit;
  logic trm_hit;
  logic done;
  logic [4:0] nl;
  logic hit;
  logic [4:0] mlen_e;
  logic [15:0][7:0] mk;
  logic [31:0] ival;
  logic [15:0] wv;
  logic [1:0] p;
  logic [3:0] o;
  logic [3:0] oj;
  logic [7:0] fc;

  // Case folding always drops the top bit first
  function automatic logic [7:0] fold(input logic [7:0] c,
                                      input logic cap);
    logic [7:0] r;
    r = {1'b0, c[6:0]};
    if (cap && r >= CH_LA && r <= CH_LZ) begin
      r = r - CASE_OFS;
    end
    return r;
  endfunction

  function automatic logic is_digit(input logic [6:0] c);
    return c >= CH_D0 && c <= CH_D9;
  endfunction

  // Stalled by a message still waiting for processing, or by RTS_LEVEL or more characters collected while the engine is busy
  assign rts = !(st_ff.pend ||
                 (st_ff.ph != P_IDLE && st_ff.clen >= RTS_LEVEL));
  assign rdata = st_ff.rdata;
  assign term_led = st_ff.term_led;
  assign pat_led = st_ff.pat_led;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.term_led = 1'b0;
    nxt_st.pat_led = 1'b0;
    nxt_st.rdata = '0;
    p = addr[5:4];
    o = addr[3:0];
    oj = o - PO_PAT;
    done = 1'b0;
    nl = st_ff.clen;
    hit = 1'b0;
    mk = '0;
    ival = '0;
    wv = '0;
    fc = '0;

    // Seven-bit ports never see the top bit
    ch = st_ff.seven ? {1'b0, rx_data[6:0]} : rx_data;
    // Lookups use the whole byte
    acc_hit = st_ff.acc[ch];
    trm_hit = st_ff.trm[ch];

    // Register writes
    if (wr) begin
      if (addr == A_CTRL) begin
        nxt_st.cap = wdata[CTRL_CAP];
        nxt_st.seven = wdata[CTRL_SEVEN];
      end else if (addr == A_TCNT) begin
        nxt_st.tcnt = wdata[4:0];
      end else if (addr == A_TOUT) begin
        nxt_st.tout = wdata[15:0];
      end else if (addr[7:3] == A_ACC_HI) begin
        nxt_st.acc[{addr[2:0], 5'd0} +: 32] = wdata;
      end else if (addr[7:3] == A_TRM_HI) begin
        nxt_st.trm[{addr[2:0], 5'd0} +: 32] = wdata;
      end else if (addr[7:6] == A_PATH_HI) begin
        if (o == PO_CFG) begin
          nxt_st.start[p] = wdata[CFG_START +: 4];
          nxt_st.cnt[p] = wdata[CFG_COUNT +: 5];
          nxt_st.fmt[p] = wdata[CFG_FMT +: 2];
          nxt_st.cont[p] = wdata[CFG_CONT];
        end else if (o == PO_LEN) begin
          nxt_st.plen[p] = wdata[LEN_PAT +: 5];
          nxt_st.mlen[p] = wdata[LEN_MSK +: 5];
        end else if (o >= PO_PAT && o < PO_MSK) begin
          for (int b = 0; b < 4; b++) begin
            nxt_st.pat[p][{oj[1:0], 2'(b)}] = wdata[8*b +: 8];
          end
        end else if (o >= PO_MSK && o < PO_MSK + 4'd4) begin
          for (int b = 0; b < 4; b++) begin
            nxt_st.msk[p][{oj[1:0], 2'(b)}] = wdata[8*b +: 8];
          end
        end
      end
    end

    // Register reads; unmapped addresses read zero
    if (rd) begin
      if (addr == A_CTRL) begin
        nxt_st.rdata = {30'd0, st_ff.seven, st_ff.cap};
      end else if (addr == A_TCNT) begin
        nxt_st.rdata = {27'd0, st_ff.tcnt};
      end else if (addr == A_TOUT) begin
        nxt_st.rdata = {16'd0, st_ff.tout};
      end else if (addr == A_SIG) begin
        nxt_st.rdata = {16'd0, st_ff.sig};
      end else if (addr == A_STAT) begin
        nxt_st.rdata = {24'd0, rts, st_ff.pend,
                        st_ff.ph != P_IDLE, st_ff.clen};
      end else if (addr[7:3] == A_ACC_HI) begin
        nxt_st.rdata = st_ff.acc[{addr[2:0], 5'd0} +: 32];
      end else if (addr[7:3] == A_TRM_HI) begin
        nxt_st.rdata = st_ff.trm[{addr[2:0], 5'd0} +: 32];
      end else if (addr[7:6] == A_PATH_HI && o == PO_CFG) begin
        nxt_st.rdata = {7'd0, st_ff.cont[p], 6'd0, st_ff.fmt[p],
                        3'd0, st_ff.cnt[p], 4'd0, st_ff.start[p]};
      end else if (addr[7:6] == A_PATH_HI && o == PO_LEN) begin
        nxt_st.rdata = {19'd0, st_ff.mlen[p], 3'd0, st_ff.plen[p]};
      end else if (addr[7:4] == A_IMG_HI) begin
        nxt_st.rdata = {16'd0, st_ff.img[addr[3:0]]};
      end else if (addr[7:4] == A_IST_HI) begin
        // This port only feeds the controller
        nxt_st.rdata = {16'd0, STAT_IN};
      end
    end

    // Hundredth-second tick for the silence counter
    if (st_ff.tick >= 32'(TICK_CYC - 1)) begin
      nxt_st.tick = '0;
      if (st_ff.sil != 16'hffff) begin
        nxt_st.sil = st_ff.sil + 16'd1;
      end
    end else begin
      nxt_st.tick = st_ff.tick + 32'd1;
    end

    // Character intake; a waiting message blocks new input
    if (rx_valid && !st_ff.pend) begin
      nxt_st.sil = '0;
      if (acc_hit && st_ff.clen < 5'(MSG_MAX)) begin
        nxt_st.cbuf[st_ff.clen[3:0]] = ch;
        nl = st_ff.clen + 5'd1;
      end
      // Neither table: buffer untouched
      done = trm_hit ||
             (st_ff.tcnt != 5'd0 && nl >= st_ff.tcnt) ||
             nl == 5'(MSG_MAX);
      nxt_st.clen = nl;
    end else if (!st_ff.pend && st_ff.tout != 16'd0 &&
                 st_ff.sil >= st_ff.tout) begin
      done = 1'b1;
    end
    // Empty terminations are silent
    if (done && nl != 5'd0) begin
      nxt_st.term_led = 1'b1;
      nxt_st.pend = 1'b1;
    end

    // Pattern test for the current path
    hit = st_ff.plen[st_ff.pi] == 5'd0 ||
          st_ff.plen[st_ff.pi] == st_ff.wlen;
    for (int i = 0; i < MSG_MAX; i++) begin
      if (5'(i) < st_ff.plen[st_ff.pi] &&
          fold(st_ff.wbuf[i], st_ff.cap) !=
          {1'b0, st_ff.pat[st_ff.pi][i][6:0]}) begin
        hit = 1'b0;
      end
    end

    // Masking
    mlen_e = st_ff.wlen < st_ff.mlen[st_ff.pi] ?
             st_ff.wlen : st_ff.mlen[st_ff.pi];
    for (int i = 0; i < MSG_MAX; i++) begin
      if (5'(i) < mlen_e) begin
        fc = fold(st_ff.wbuf[i], st_ff.cap);
        if (st_ff.msk[st_ff.pi][i] == CH_US) begin
          mk[i] = {st_ff.wbuf[i][7], fc[6:0]};
        end else begin
          mk[i] = {1'b0, st_ff.msk[st_ff.pi][i][6:0]};
        end
        // Numbers ignore the top bit and any non-digit
        if (is_digit(mk[i][6:0])) begin
          ival = 32'(ival * 32'd10) + {28'd0, mk[i][3:0]};
        end
      end
    end

    // Edited word for register k of the path
    unique case (st_ff.fmt[st_ff.pi])
      FMT_ASCII: begin
        wv = st_ff.k < 5'(MSG_MAX) ? {8'h00, mk[st_ff.k[3:0]]} : '0;
      end
      FMT_PACKED: begin
        wv = st_ff.k < 5'(MSG_MAX / 2) ?
             {mk[{st_ff.k[2:0], 1'b0}], mk[{st_ff.k[2:0], 1'b1}]} : '0;
      end
      FMT_INT: begin
        wv = st_ff.k == 5'd0 ? ival[15:0] : '0;
      end
      FMT_FLOAT: begin
        wv = st_ff.k == 5'd0 ? ival[31:16] :
             st_ff.k == 5'd1 ? ival[15:0] : '0;
      end
    endcase

    unique case (st_ff.ph)
      P_IDLE: begin
      end
      P_MATCH: begin
        if (hit) begin
          // Toggle even when no data will change
          nxt_st.sig[{PORT_IDX, st_ff.pi}] = !st_ff.sig[{PORT_IDX,
                                                          st_ff.pi}];
          nxt_st.pat_led = 1'b1;
          nxt_st.k = '0;
          nxt_st.ph = P_WRITE;
        end else if (st_ff.pi == 2'(NPATH - 1)) begin
          nxt_st.ph = P_IDLE;
        end else begin
          nxt_st.pi = st_ff.pi + 2'd1;
        end
      end
      P_WRITE: begin
        if (st_ff.k < st_ff.cnt[st_ff.pi]) begin
          // Wraps inside the image table
          nxt_st.img[4'(st_ff.start[st_ff.pi] + st_ff.k[3:0])] = wv;
          nxt_st.k = st_ff.k + 5'd1;
        end else if (st_ff.cont[st_ff.pi] &&
                     st_ff.pi != 2'(NPATH - 1)) begin
          nxt_st.pi = st_ff.pi + 2'd1;
          nxt_st.ph = P_MATCH;
        end else begin
          nxt_st.ph = P_IDLE;
        end
      end
    endcase

    // Hand a finished message to the path engine
    if (nxt_st.pend && st_ff.ph == P_IDLE) begin
      nxt_st.wbuf = nxt_st.cbuf;
      nxt_st.wlen = nxt_st.clen;
      nxt_st.clen = '0;
      nxt_st.pend = 1'b0;
      nxt_st.pi = '0;
      nxt_st.ph = P_MATCH;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= ST_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  drop_neither_a: assert property (@(posedge clk) disable iff (reset)
    ce && rx_valid && !st_ff.pend && !acc_hit && !trm_hit
    |=> st_ff.clen == $past(st_ff.clen) || st_ff.clen == 5'd0)
    else $error("rejected character changed buffer");

  append_char_a: assert property (@(posedge clk) disable iff (reset)
    ce && rx_valid && !st_ff.pend && acc_hit && !trm_hit &&
    st_ff.tcnt == 5'd0 && st_ff.clen < 5'd15
    |=> st_ff.clen == $past(st_ff.clen) + 5'd1 &&
        st_ff.cbuf[$past(st_ff.clen[3:0])] == $past(ch))
    else $error("accepted character not appended");

  term_flash_a: assert property (@(posedge clk) disable iff (reset)
    term_led |-> $past(nl) != 5'd0 && (st_ff.pend || st_ff.ph == P_MATCH))
    else $error("terminator flash without message");

  toggle_sig_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_ff.ph == P_MATCH && hit
    |=> pat_led && $countones(st_ff.sig ^ $past(st_ff.sig)) == 1)
    else $error("trigger did not toggle one bit");

  no_match_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_ff.ph == P_MATCH && !hit && st_ff.pi == 2'd3
    |=> st_ff.ph != P_WRITE && !pat_led)
    else $error("unmatched message was processed");

  int_fill_a: assert property (@(posedge clk) disable iff (reset)
    st_ff.ph == P_WRITE && st_ff.k != 5'd0 &&
    st_ff.fmt[st_ff.pi] == FMT_INT |-> wv == 16'h0000)
    else $error("integer wrote more than one register");

  rts_backlog_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_ff.pend && st_ff.ph == P_IDLE |=> !st_ff.pend && rts)
    else $error("rts not restored after backlog");

  seven_bit_a: assert property (@(posedge clk) disable iff (reset)
    ce && rx_valid && st_ff.seven && acc_hit && !st_ff.pend &&
    st_ff.clen < 5'd15
    |=> st_ff.cbuf[$past(st_ff.clen[3:0])][7] == 1'b0)
    else $error("seven-bit mode kept top bit");

  stat_word_a: assert property (@(posedge clk) disable iff (reset)
    ce && rd && addr[7:4] == A_IST_HI |=> rdata == {16'd0, STAT_IN})
    else $error("wrong register status word");
endmodule

// >>> aimr_router_tb.sv
/*
  Self-checking bench for the ASCII input message router: register
  port tasks, one task per scenario, sender model on the link.
  Assumes the design package and a 125 MHz clock.
*/
`timescale 1ns/1ps
module aimr_router_tb;
  import aimr_pkg::*;
  logic clk, reset, ce, wr, rd, slow, rts, rx_valid, rts_low;
  logic term_led, pat_led;
  logic [7:0] addr, rx_data;
  logic [31:0] wdata, rdata, esig;
  logic [255:0] acc, trm;
  localparam logic [31:0] MSK = 32'h5f5f5f5f;
  int err_count = 0;
  int tests_run = 0;
  int nterm = 0;
  int npat = 0;
  int t0, p0;

  // Short tick keeps silence tests brief; port 1 moves signal bits up
  aimr_router #(.TICK_CYC(10), .PORT_IDX(2'd1)) dut (.clk(clk),
    .reset(reset), .ce(ce), .rx_data(rx_data), .rx_valid(rx_valid),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rts(rts), .term_led(term_led), .pat_led(pat_led));
  aimr_scanner scn (.clk(clk), .reset(reset), .rts(rts), .slow(slow),
    .rx_data(rx_data), .rx_valid(rx_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (term_led === 1'b1) nterm <= nterm + 1;
    if (pat_led === 1'b1) npat <= npat + 1;
    if (!reset && rts === 1'b0) rts_low <= 1'b1;
  end

  task end_of_test;
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask

  task en(input string a, input string t);
    acc = '0;
    trm = '0;
    // String bytes are signed; codes above 7f would index out of range
    for (int i = 0; i < a.len(); i++) acc[unsigned'(a[i])] = 1'b1;
    for (int i = 0; i < t.len(); i++) trm[unsigned'(t[i])] = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wreg(8'(16 + i), acc[32*i+:32]);
      wreg(8'(24 + i), trm[32*i+:32]);
    end
  endtask

  function logic [31:0] cf(input logic c, input logic [1:0] f,
                           input logic [4:0] n, input logic [3:0] s);
    return {7'h0, c, 6'h0, f, 3'h0, n, 4'h0, s};
  endfunction

  task path(input int p, input logic [31:0] cfg, input logic [4:0] ml,
            input logic [4:0] pl, input logic [31:0] pat);
    logic [7:0] b;
    b = 8'(64 + 16 * p);
    wreg(b, cfg);
    wreg(b + 8'h01, {19'h0, ml, 3'h0, pl});
    wreg(b + 8'h02, pat);
    wreg(b + 8'h06, MSK);
  endtask

  // Waits for the sender to drain, then for the engine to settle
  task msg(input string s);
    for (int i = 0; i < s.len(); i++) scn.put(s[i]);
    for (int k = 0; k < 300 && scn.q.size() > 0; k++) @(posedge clk);
    chk("drain", 32'h0, 32'(scn.q.size()));
    repeat (60) @(posedge clk);
  endtask

  task t_reset;
    rchk("sig", A_SIG, 32'h0);
    rchk("stat0", 8'ha0, {16'h0, STAT_IN});
    rchk("stat15", 8'haf, {16'h0, STAT_IN});
    chk("rts", 32'h1, {31'h0, rts});
  endtask

  task t_int;
    en("123", "\015");
    path(0, cf(0, FMT_INT, 1, 2), 2, 0, 0);
    t0 = nterm;
    p0 = npat;
    msg("123\015");
    esig ^= 32'h10;
    chk("term", t0 + 1, nterm);
    chk("pat", p0 + 1, npat);
    rchk("img2", 8'h82, 32'd12);
    rchk("sig", A_SIG, esig);
    msg("1x2\015");
    esig ^= 32'h10;
    rchk("img2b", 8'h82, 32'd12);
    rchk("sig2", A_SIG, esig);
  endtask

  task t_ascii;
    en("ab\343d", "d");
    wreg(A_CTRL, 32'h1);
    wreg(8'h46, 32'h5f5f5a5f);
    path(0, cf(0, FMT_ASCII, 4, 5), 4, 0, 0);
    wreg(8'h46, 32'h5f5f5a5f);
    msg("ab\343d");
    esig ^= 32'h10;
    rchk("img5", 8'h85, 32'h41);
    rchk("img6", 8'h86, 32'h5a);
    rchk("img7", 8'h87, 32'hc3);
    rchk("img8", 8'h88, 32'h44);
    wreg(A_CTRL, 32'h0);
  endtask

  // Two triggers per run leave the signal bit where it was
  task t_float;
    en("1239", "\015");
    path(0, cf(0, FMT_ASCII, 3, 10), 4, 0, 0);
    msg("999\015");
    rchk("fill", 8'h8c, 32'h39);
    path(0, cf(0, FMT_FLOAT, 3, 10), 4, 0, 0);
    msg("123\015");
    rchk("f_hi", 8'h8a, 32'h0);
    rchk("f_lo", 8'h8b, 32'd123);
    rchk("f_pad", 8'h8c, 32'h0);
  endtask

  task t_order;
    en("ABX", "\015");
    path(0, cf(0, FMT_INT, 0, 0), 4, 2, 32'h4241);
    path(1, cf(0, FMT_INT, 0, 0), 4, 0, 0);
    path(2, cf(0, FMT_INT, 0, 0), 4, 1, 32'h51);
    path(3, cf(0, FMT_INT, 0, 0), 4, 1, 32'h51);
    p0 = npat;
    msg("AB\015");
    esig ^= 32'h10;
    chk("pat1", p0 + 1, npat);
    rchk("sig1", A_SIG, esig);
    path(0, cf(1, FMT_INT, 0, 0), 4, 2, 32'h4241);
    p0 = npat;
    msg("AB\015");
    esig ^= 32'h30;
    chk("pat2", p0 + 2, npat);
    rchk("sig2", A_SIG, esig);
    path(1, cf(0, FMT_INT, 0, 0), 4, 1, 32'h51);
    p0 = npat;
    msg("XB\015");
    chk("pat3", p0, npat);
    t0 = nterm;
    msg("\015");
    chk("term0", t0, nterm);
    msg("AB\015");
    esig ^= 32'h10;
    rchk("sig3", A_SIG, esig);
  endtask

  task t_limits;
    en("1234", "");
    path(0, cf(0, FMT_INT, 1, 3), 4, 0, 0);
    wreg(A_TCNT, 32'd2);
    msg("12");
    rchk("len", 8'h83, 32'd12);
    wreg(A_TCNT, 32'd0);
    wreg(A_TOUT, 32'd2);
    msg("134");
    esig ^= 32'h0;
    rchk("tout", 8'h83, 32'd134);
    wreg(A_TOUT, 32'd0);
  endtask

  task t_seven;
    en("12", "\015");
    wreg(A_CTRL, 32'h2);
    path(0, cf(0, FMT_INT, 1, 4), 4, 0, 0);
    slow <= 1'b1;
    msg("\261\262\015");
    esig ^= 32'h10;
    rchk("seven", 8'h84, 32'd12);
    wreg(A_CTRL, 32'h0);
  endtask

  // Slow sender so each pause is seen before the next byte leaves
  task t_rts;
    en("123", "\015");
    path(0, cf(0, FMT_ASCII, 16, 0), 4, 0, 0);
    rts_low <= 1'b0;
    t0 = nterm;
    msg("1\0152\0153\015");
    esig ^= 32'h10;
    chk("rts_low", 32'h1, {31'h0, rts_low});
    chk("term3", t0 + 3, nterm);
    rchk("img0", 8'h80, 32'h33);
    rchk("sig", A_SIG, esig);
  endtask

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    slow = 1'b0;
    esig = 32'h0;
    rts_low = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_int;
    t_ascii;
    t_float;
    t_order;
    t_limits;
    t_seven;
    t_rts;
    end_of_test;
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_of_test;
  end
endmodule

// >>> aimr_scanner.sv
/*
  Sender model for the receive link: a serial ASCII source that
  honours the ready-to-send line, prompt or one byte every other cycle.
  Assumes the bench clock and that the bench queues bytes with put.
*/
`timescale 1ns/1ps
module aimr_scanner (
  input wire logic clk,
  input wire logic reset,
  input wire logic rts,
  input wire logic slow,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [7:0] q[$];
  logic hold = 1'b0;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end

  task put(input logic [7:0] b);
    q.push_back(b);
  endtask

  // Idle data line keeps changing so a stale byte can never pass
  always @(posedge clk) begin
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    hold <= slow && !hold;
    if (!reset && rts && !hold && q.size() > 0) begin
      rx_data <= q.pop_front();
      rx_valid <= 1'b1;
    end
  end
endmodule
